// ==== logic/bridge_intx_msi_mapper.sv ====
// Function
// - MSI enable disables pins, but forward-mode PCI pin messages still go upstream alongside MSI.
// - MSI writes carry a full 64-bit address.
// - reverse mode maps received messages to pins, or MSI when enabled.
// - forward mode converts PCI pins into upstream messages.
// - eight message types: assert and deassert for INTA..INTD.
// - reverse mode: message letter drives same pin letter.
// - forward mode: pin letter reported with same message letter.
// - internal requests appear as INTA pin/message, or MSI.
//
// top of the bridge legacy interrupt mapper; runs on the bridge core clock
// assumes all inputs synchronous to CLK, message sink accepts when MSG_READY
`timescale 1ns/1ps
module bridge_intx_msi_mapper
  import intx_map_pkg::*;
(
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire logic                   CE,
  input  wire logic                   REVERSE_MODE,
  input  wire intx_map_pkg::msi_cfg_t MSI_CFG,
  input  wire logic [3:0]             PCI_INT_N_IN,
  input  wire logic                   INTERNAL_IRQ,
  input  wire intx_map_pkg::intx_msg_t RX_MSG,
  input  wire logic                   MSG_READY,
  input  wire logic                   MSI_READY,
  output intx_map_pkg::intx_msg_t     TX_MSG,
  output logic [3:0]                  PCI_INT_N_OUT,
  output logic [3:0]                  PCI_INT_OE,
  output intx_map_pkg::msi_req_t      MSI_REQ
);
  import intx_map_pkg::*;

  // tracked levels and last reported levels
  logic [3:0] rx_level_ff;
  logic [3:0] reported_ff;
  logic [3:0] nxt_rx_level;
  logic [3:0] msg_level;
  logic [3:0] pin_level;
  logic       irq_to_msg;
  logic       chg_hit;
  logic [1:0] chg_idx;
  logic       msi_pend_ff;
  logic       any_active_ff;
  logic       msg_busy;
  logic       msi_busy;

  // decode a message code into its wire and direction
  function automatic logic is_deassert(input logic [MSG_W-1:0] c);
    return c[MSG_DEASSERT];
  endfunction

  function automatic logic [1:0] wire_of(input logic [MSG_W-1:0] c);
    return c[1:0];
  endfunction

  // virtual wire levels from received messages (reverse mode)
  always_comb begin
    nxt_rx_level = rx_level_ff;
    if (RX_MSG.valid) begin
      nxt_rx_level[wire_of(RX_MSG.code)] = ~is_deassert(RX_MSG.code);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_level_ff <= WIRES_RST;
    end else if (CE && REVERSE_MODE) begin
      rx_level_ff <= nxt_rx_level;
    end
  end

  // message side: PCI pins in forward mode (active low); in reverse mode only
  // the internal request travels upstream, as INTA messages, while MSI is off
  // pin side: received wires in reverse mode; in forward mode only the
  // internal request, shown on INTA or carried by MSI
  always_comb begin
    irq_to_msg = REVERSE_MODE && !MSI_CFG.enable;
    msg_level  = REVERSE_MODE ? WIRES_RST : ~PCI_INT_N_IN;
    pin_level  = REVERSE_MODE ? rx_level_ff : WIRES_RST;
    msg_level[WIRE_INTA] = msg_level[WIRE_INTA] | (INTERNAL_IRQ && irq_to_msg);
    pin_level[WIRE_INTA] = pin_level[WIRE_INTA] | (INTERNAL_IRQ && !irq_to_msg);
  end

  intx_edge_picker #(
    .N (NUM_WIRES)
  ) u_picker (
    .level    (msg_level),
    .reported (reported_ff),
    .hit      (chg_hit),
    .idx      (chg_idx)
  );

  assign msg_busy = TX_MSG.valid && !MSG_READY;
  assign msi_busy = MSI_REQ.valid && !MSI_READY;

  // messages out: one per level change, held until accepted
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      TX_MSG      <= '0;
      reported_ff <= WIRES_RST;
    end else if (CE) begin
      if (!msg_busy) begin
        TX_MSG.valid <= 1'b0;
        if (chg_hit) begin
          TX_MSG.valid <= 1'b1;
          TX_MSG.code  <= {~msg_level[chg_idx], chg_idx};
          reported_ff[chg_idx] <= msg_level[chg_idx];
        end
      end
    end
  end

  // interrupt pins: open-drain, pulled low only while MSI is off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PCI_INT_N_OUT <= WIRES_RST;
      PCI_INT_OE    <= WIRES_RST;
    end else if (CE) begin
      PCI_INT_N_OUT <= WIRES_RST;
      PCI_INT_OE    <= MSI_CFG.enable ? WIRES_RST : pin_level;
    end
  end

  // MSI: one write per rising summary level while MSI enabled, in either mode
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MSI_REQ       <= '0;
      msi_pend_ff   <= 1'b0;
      any_active_ff <= 1'b0;
    end else if (CE) begin
      any_active_ff <= |pin_level;
      if (MSI_CFG.enable && (|pin_level) && !any_active_ff) begin
        msi_pend_ff <= 1'b1;
      end else if (!msi_busy && msi_pend_ff) begin
        msi_pend_ff <= 1'b0;
      end
      if (!msi_busy) begin
        MSI_REQ.valid <= msi_pend_ff;
        MSI_REQ.addr  <= MSI_CFG.addr;
        MSI_REQ.data  <= MSI_CFG.data;
      end
    end
  end

  // pins never driven while MSI enabled
  a_pins_off_msi: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && MSI_CFG.enable) |=> (PCI_INT_OE == 4'h0))
    else $error("pin driven while msi enabled");

  // pending MSI goes out next cycle, carrying the full address
  a_msi_addr_full: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && !msi_busy && msi_pend_ff) |=> (MSI_REQ.valid && MSI_REQ.addr == $past(MSI_CFG.addr)))
    else $error("msi address not full width");

  // reverse mode pin follows same-letter virtual wire
  a_rev_map: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && REVERSE_MODE && !MSI_CFG.enable) |=> (PCI_INT_OE == $past(rx_level_ff)))
    else $error("reverse pin mapping wrong");

  // received assert raises its wire next cycle
  a_rx_assert: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && REVERSE_MODE && RX_MSG.valid) |=>
      (rx_level_ff[$past(RX_MSG.code[1:0])] == !$past(RX_MSG.code[MSG_DEASSERT])))
    else $error("received message not applied");

  // forward message letter and direction match the changed pin
  a_fwd_letter: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && !REVERSE_MODE && !msg_busy && chg_hit) |=>
      (TX_MSG.valid && TX_MSG.code[1:0] == $past(chg_idx)
       && TX_MSG.code[MSG_DEASSERT] == !$past(msg_level[chg_idx])))
    else $error("forward message letter wrong");

  // no message while levels steady
  a_no_repeat: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && !msg_busy && !chg_hit) |=> !TX_MSG.valid)
    else $error("message sent without change");

  // held message stays stable until accepted
  a_msg_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && msg_busy) |=> (TX_MSG == $past(TX_MSG)))
    else $error("message changed while stalled");

  // internal request shows on the INTA pin in forward mode
  a_internal_inta: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && INTERNAL_IRQ && !REVERSE_MODE && !MSI_CFG.enable) |=> PCI_INT_OE[WIRE_INTA])
    else $error("internal request not on inta pin");

  // internal request in reverse mode goes out as an INTA assert message
  a_int_rev_msg: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && irq_to_msg && INTERNAL_IRQ && !reported_ff[WIRE_INTA] && !msg_busy) |=>
      (TX_MSG.valid && TX_MSG.code == {1'b0, WIRE_INTA}))
    else $error("internal request not sent as inta message");

  // message direction matches the level now tracked for its letter
  a_msg_dir_track: assert property (@(posedge CLK) disable iff (!RSTN)
    TX_MSG.valid |-> (TX_MSG.code[MSG_DEASSERT] == !reported_ff[TX_MSG.code[1:0]]))
    else $error("message direction does not match tracked level");

  // received messages leave the virtual wires alone in forward mode
  a_rx_ignored_fwd: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && !REVERSE_MODE) |=> $stable(rx_level_ff))
    else $error("received message applied in forward mode");

  // no MSI write is raised while MSI is off and nothing is pending
  a_msi_off_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && !MSI_CFG.enable && !msi_pend_ff && !MSI_REQ.valid) |=> !MSI_REQ.valid)
    else $error("msi raised while disabled");

  // a stalled MSI write keeps its full address and data
  a_msi_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    (CE && msi_busy) |=> $stable(MSI_REQ))
    else $error("msi changed while stalled");

  // clock enable low freezes every output
  a_ce_freeze: assert property (@(posedge CLK) disable iff (!RSTN)
    !CE |=> ($stable(TX_MSG) && $stable(PCI_INT_OE) && $stable(MSI_REQ)))
    else $error("output moved while clock enable low");

endmodule

// ==== logic/intx_map_pkg.sv ====
// package for the legacy interrupt mapper: message codes, structs, constants
// assumes nothing beyond a SystemVerilog compiler
package intx_map_pkg;

  // number of virtual interrupt wires (INTA..INTD)
  localparam int NUM_WIRES = 4;

  // message code layout: bit 2 = deassert, bits 1:0 = wire letter
  localparam int MSG_W        = 3;
  localparam int MSG_DEASSERT = 2;

  // wire index of INTA, used by internal requests
  localparam logic [1:0] WIRE_INTA = 2'h0;

  // MSI enable position in config dword F0h
  localparam logic [11:0] MSI_CFG_OFFSET = 12'hF0;
  localparam int          MSI_EN_BIT     = 16;

  // MSI address is full 64 bits
  localparam int MSI_ADDR_W = 64;
  localparam int MSI_DATA_W = 16;

  // reset values
  localparam logic [3:0] WIRES_RST = 4'h0;

  // received or sent interrupt message
  typedef struct packed {
    logic             valid;
    logic [MSG_W-1:0] code;
  } intx_msg_t;

  // MSI write request
  typedef struct packed {
    logic                  valid;
    logic [MSI_ADDR_W-1:0] addr;
    logic [MSI_DATA_W-1:0] data;
  } msi_req_t;

  // MSI capability settings from configuration space
  typedef struct packed {
    logic                  enable;
    logic [MSI_ADDR_W-1:0] addr;
    logic [MSI_DATA_W-1:0] data;
  } msi_cfg_t;

endpackage

// ==== logic/intx_edge_picker.sv ====
// priority picker: finds the lowest-numbered wire whose level differs
// from the level last reported; purely combinational, level fed unregistered from the inputs
`timescale 1ns/1ps
module intx_edge_picker
  import intx_map_pkg::*;
#(
  parameter int N = NUM_WIRES
) (
  input  wire logic [N-1:0] level,
  input  wire logic [N-1:0] reported,
  output logic              hit,
  output logic [1:0]        idx
);

  // pick the first changed wire
  always_comb begin
    hit = 1'b0;
    idx = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (level[i] != reported[i]) begin
        hit = 1'b1;
        idx = 2'(i);
      end
    end
  end

endmodule

// ==== dv/intx_ready_model.sv ====
// far side sink model: takes messages and MSI writes with random stalls
// assumes the bench seeds $urandom before reset is released
`timescale 1ns/1ps
module intx_ready_model (
  input  wire logic CLK,
  output logic      MSG_READY,
  output logic      MSI_READY
);
  // ready changes just after each edge, stalling about half the time
  initial begin
    MSG_READY = 1'b0;
    MSI_READY = 1'b0;
    forever begin
      @(posedge CLK);
      #1;
      MSG_READY = 1'($urandom_range(1));
      MSI_READY = 1'($urandom_range(1));
    end
  end
endmodule

// ==== dv/tb.sv ====
// bench for the legacy interrupt mapper: forward, reverse and MSI paths
// assumes the ready model stalls both sinks at random
`timescale 1ns/1ps
module tb;
  import intx_map_pkg::*;
  logic       clk = 0, rstn = 0, rev = 0, irq = 0, ce = 1, mrdy, irdy;
  logic [3:0] pin_n = 4'hF, oe, out_n;
  msi_cfg_t   cfg = '0;
  intx_msg_t  rx = '0, tx;
  msi_req_t   msi;
  int         mismatches = 0, tests_run = 0, cyc = 0;
  logic [2:0] mq[$];
  msi_req_t   iq[$];
  bridge_intx_msi_mapper uut (.CLK(clk), .RSTN(rstn), .CE(ce), .REVERSE_MODE(rev),
    .MSI_CFG(cfg), .PCI_INT_N_IN(pin_n), .INTERNAL_IRQ(irq), .RX_MSG(rx),
    .MSG_READY(mrdy), .MSI_READY(irdy), .TX_MSG(tx), .PCI_INT_N_OUT(out_n),
    .PCI_INT_OE(oe), .MSI_REQ(msi));
  intx_ready_model far (.CLK(clk), .MSG_READY(mrdy), .MSI_READY(irdy));
  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(string nm, logic [80:0] seen, logic [80:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // each accepted message or MSI write takes the oldest note; extras mismatch
  always @(posedge clk) begin
    if (rstn && ce && tx.valid === 1'b1 && mrdy)
      chk("tx_msg", tx.code, mq.size() ? mq.pop_front() : 'x);
    if (rstn && ce && msi.valid === 1'b1 && irdy)
      chk("msi_req", msi, iq.size() ? iq.pop_front() : 'x);
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait for all notes to be met, then watch for repeats
  task automatic drain();
    int k;
    k = 0;
    while ((mq.size() || iq.size()) && k < 200) begin
      tick(1);
      k++;
    end
    chk("drained", mq.size() + iq.size(), 0);
    tick(12);
  endtask
  task automatic send(logic [2:0] c);
    rx = '{1'b1, c};
    tick(1);
    rx = '0;
    tick(3);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h4C5EEB56));
    tick(20);
    rstn = 1;
    tick(2);
    pin_n = 4'h0;
    mq = '{3'h0, 3'h1, 3'h2, 3'h3};
    drain();
    pin_n = 4'hF;
    mq = '{3'h4, 3'h5, 3'h6, 3'h7};
    drain();
    // forward mode: internal request drives the INTA pin, sends no message
    irq = 1;
    tick(3);
    chk("oe_int", oe, 4'h1);
    drain();
    irq = 0;
    tick(3);
    chk("oe_int_off", oe, 4'h0);
    drain();
    // clock enable low holds off the INTB message until it returns
    ce = 0;
    pin_n = 4'hD;
    tick(4);
    chk("ce_frozen", {tx.valid, oe}, 5'h0);
    ce = 1;
    mq.push_back(3'h1);
    drain();
    pin_n = 4'hF;
    mq.push_back(3'h5);
    drain();
    // a received message in forward mode must not reach the wires
    send({1'b0, 2'h3});
    $display("test forward done");
    rev = 1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      send({1'b0, 2'(i)});
      chk("oe_on", oe, 4'h1 << i);
      send({1'b1, 2'(i)});
      chk("oe_off", oe, 4'h0);
    end
    chk("out_n", out_n, 4'h0);
    // reverse mode: internal request goes out as INTA messages, not pins
    irq = 1;
    mq.push_back(3'h0);
    drain();
    chk("oe_int_rev", oe, 4'h0);
    irq = 0;
    mq.push_back(3'h4);
    drain();
    $display("test reverse done");
    cfg = '{1'b1, {$urandom, $urandom}, 16'($urandom)};
    for (int i = 0; i < 2; i++) begin
      iq.push_back('{1'b1, cfg.addr, cfg.data});
      send({1'b0, 2'(i)});
      chk("oe_msi", oe, 4'h0);
      send({1'b1, 2'(i)});
      drain();
    end
    // internal request carried by MSI, in reverse and then forward mode
    for (int m = 0; m < 2; m++) begin
      rev = (m == 0);
      tick(2);
      iq.push_back('{1'b1, cfg.addr, cfg.data});
      irq = 1;
      tick(4);
      chk("oe_irq_msi", oe, 4'h0);
      irq = 0;
      drain();
    end
    $display("test msi done");
    close_out();
  end
endmodule
